// *** logic/abrs_ram_slave.sv ***
// Decided for this implementation: the address map and the AXI4 burst slave port.
`timescale 1ns/1ps
// Notes on behaviour
// RL1 - narrow beats rotate byte lanes per address
// RL2 - every bus beat is one memory access
// RL3 - write strobes drive byte write enables directly
// RL4 - narrow burst advances word at boundary only
// RL5 - half-word size alternates upper, lower lanes
// RL6 - unaligned word burst start handled correctly
// RL7 - memory mode decodes at least 4kB
// RL8 - peripheral mode allows depth of two; DEPTH is fixed at 1024 words in both modes here
// RL9 - peripheral mode forces byte offset zero
// RL10 - memory mode decodes byte offset bits
// RL11 - bus addresses are 32-bit byte addresses
// RL12 - word address drops byte offset bits
// RL13 - address range starts at zero
// RL14 - address bits above range ignored
// RL15 - master avoids single writes, b stalls; the bench master stalls bready 3 cycles in t_wrap
// RL16 - master avoids read data back-pressure; the bench master holds rready low 2 cycles per beat in t_wrap
// RL17 - bus and memory widths equal
// RL18 - no output register in read path
// RL19 - init per location or one default
// RL20 - no initial contents with ecc
// RL21 - bvalid after last beat, no bready wait
// RL22 - incr bursts carry 1 to 256 beats
// RL23 - wrap bursts wrap inside aligned line
module abrs_ram_slave #(
  parameter bit mem_slave_mode = 1'b1,
  parameter bit ecc_en = 1'b0,
  parameter bit use_init_contents = 1'b0,
  parameter logic [abrs_pkg::DATA_W-1:0] init_default = 32'h0,
  parameter logic [abrs_pkg::DATA_W-1:0] init_contents_file
    [abrs_pkg::DEPTH] = '{default: 32'h0}
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address channel
  input wire logic [abrs_pkg::ADDR_W-1:0] awaddr,
  input wire logic [7:0] awlen,
  input wire logic [2:0] awsize,
  input wire logic [1:0] awburst,
  input wire logic awvalid,
  output logic awready,
  // write data channel
  input wire logic [abrs_pkg::DATA_W-1:0] wdata,
  input wire logic [abrs_pkg::STRB_W-1:0] wstrb,
  input wire logic wlast,
  input wire logic wvalid,
  output logic wready,
  // write response channel
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read address channel
  input wire logic [abrs_pkg::ADDR_W-1:0] araddr,
  input wire logic [7:0] arlen,
  input wire logic [2:0] arsize,
  input wire logic [1:0] arburst,
  input wire logic arvalid,
  output logic arready,
  // read data channel
  output logic [abrs_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rlast,
  output logic rvalid,
  input wire logic rready
);
  import abrs_pkg::*;

  // ----------------------------------------------------------------
  // address helpers
  // ----------------------------------------------------------------

  // bytes per beat, sizes above the word are clamped
  function automatic logic [MEM_AW-1:0] beat_bytes(input logic [2:0] s);
    logic [2:0] c;
    c = (s > SIZE_WORD) ? SIZE_WORD : s;
    beat_bytes = MEM_AW'(1) << c;
  endfunction

  // wrap line mask, bytes per beat times beats minus one
  function automatic logic [MEM_AW-1:0] wrap_mask(input abrs_req_t r);
    logic [MEM_AW-1:0] n;
    n = {4'h0, r.len} + MEM_AW'(1);
    wrap_mask = MEM_AW'(beat_bytes(r.size) * n) - MEM_AW'(1);
  endfunction

  // next byte address of a burst
  function automatic logic [MEM_AW-1:0] next_addr(input abrs_req_t r);
    logic [MEM_AW-1:0] b;
    logic [MEM_AW-1:0] m;
    b = beat_bytes(r.size);
    m = wrap_mask(r);
    case (r.burst)
      // incr realigns an unaligned start to the beat size
      BURST_INCR: next_addr = (r.addr & ~(b - MEM_AW'(1))) + b; // RL6 RL22
      // wrap stays inside the aligned line
      BURST_WRAP: next_addr = (r.addr & ~m) | ((r.addr + b) & m); // RL23
      default: next_addr = r.addr;
    endcase
  endfunction

  // capture of an incoming address, upper bits dropped
  function automatic abrs_req_t take_req(
    input logic [ADDR_W-1:0] a,
    input logic [7:0] l,
    input logic [2:0] s,
    input logic [1:0] bt
  );
    abrs_req_t r;
    r.addr = a[MEM_AW-1:0]; // RL11 RL13 RL14
    // memory mode keeps byte offsets, peripheral mode zeroes them
    if (!mem_slave_mode)
      r.addr[WORD_LSB-1:0] = '0; // RL9 RL8
    r.len = l;
    r.size = s;
    r.burst = bt;
    take_req = r; // RL10
  endfunction

  // ----------------------------------------------------------------
  // memory array
  // ----------------------------------------------------------------

  // one word per bus beat width, no aspect conversion
  logic [DATA_W-1:0] mem [DEPTH]; // RL17 RL7

  // power-up contents, withheld when ecc is on
  initial
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      if (ecc_en)
        mem[i] = '0; // RL20
      else if (use_init_contents)
        mem[i] = init_contents_file[i]; // RL19
      else
        mem[i] = init_default; // RL19
    end
  end

  // ----------------------------------------------------------------
  // write path
  // ----------------------------------------------------------------

  typedef enum logic [1:0] {W_IDLE, W_DATA, W_RESP} abrs_wst_t;

  abrs_wst_t w_state_q; // write state
  abrs_wst_t w_state_d;
  abrs_req_t w_req_q; // current write beat request
  logic [7:0] w_cnt_q; // beats done so far
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;

  // decode of the write side
  wire aw_fire = awvalid && awready_q;
  wire w_fire = wvalid && wready_q;
  wire w_last_beat = (w_cnt_q == w_req_q.len);
  wire b_fire = bvalid_q && bready;
  // word index, byte offset bits dropped
  wire [WORD_W-1:0] w_word = w_req_q.addr[MEM_AW-1:WORD_LSB]; // RL12

  // next write state
  always_comb
  begin
    w_state_d = w_state_q;
    case (w_state_q)
      W_IDLE: if (aw_fire) w_state_d = W_DATA;
      W_DATA: if (w_fire && w_last_beat) w_state_d = W_RESP; // RL22
      W_RESP: if (b_fire) w_state_d = W_IDLE;
      default: w_state_d = W_IDLE;
    endcase
  end

  // write state, request and handshake flops
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_state_q <= W_IDLE;
      w_req_q <= '0;
      w_cnt_q <= '0;
      awready_q <= READY_RST;
      wready_q <= VALID_RST;
      bvalid_q <= VALID_RST;
      bresp_q <= RESP_OKAY;
    end
    else
    begin
      w_state_q <= w_state_d;
      awready_q <= (w_state_d == W_IDLE);
      wready_q <= (w_state_d == W_DATA);
      // response raised on the last beat, not gated by bready
      bvalid_q <= (w_state_d == W_RESP); // RL21
      bresp_q <= RESP_OKAY;
      if (aw_fire)
      begin
        w_req_q <= take_req(awaddr, awlen, awsize, awburst);
        w_cnt_q <= '0;
      end
      else if (w_fire)
      begin
        // one beat, one step of the address
        w_req_q.addr <= next_addr(w_req_q); // RL2 RL4
        w_cnt_q <= w_cnt_q + 8'h1;
      end
    end
  end

  // byte lanes follow the address, so narrow data rotates per beat
  always @(posedge aclk)
  begin
    if (w_fire)
    begin
      for (int i = 0; i < STRB_W; i++)
      begin
        if (wstrb[i])
          mem[w_word][8*i +: 8] <= wdata[8*i +: 8]; // RL1 RL3 RL5
      end
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------

  typedef enum logic {R_IDLE, R_DATA} abrs_rst_t;

  abrs_rst_t r_state_q; // read state
  abrs_req_t r_req_q; // current read beat request
  logic [7:0] r_cnt_q; // beats sent so far
  logic arready_q;
  logic rvalid_q;
  logic rlast_q;
  logic [1:0] rresp_q;
  logic [DATA_W-1:0] rdata_q;

  // decode of the read side
  wire ar_fire = arvalid && arready_q;
  wire r_fire = rvalid_q && rready;
  wire r_last_beat = (r_cnt_q == r_req_q.len);
  wire abrs_req_t ar_req = take_req(araddr, arlen, arsize, arburst);
  wire abrs_req_t r_next = '{addr: next_addr(r_req_q), len: r_req_q.len,
    size: r_req_q.size, burst: r_req_q.burst};
  wire [WORD_W-1:0] ar_word = ar_req.addr[MEM_AW-1:WORD_LSB]; // RL12
  wire [WORD_W-1:0] rn_word = r_next.addr[MEM_AW-1:WORD_LSB];

  // single ram read stage feeds rdata, nothing added behind it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r_state_q <= R_IDLE;
      r_req_q <= '0;
      r_cnt_q <= '0;
      arready_q <= READY_RST;
      rvalid_q <= VALID_RST;
      rlast_q <= 1'h0;
      rresp_q <= RESP_OKAY;
      rdata_q <= '0;
    end
    else
    begin
      rresp_q <= RESP_OKAY;
      case (r_state_q)
        R_IDLE:
          if (ar_fire)
          begin
            r_state_q <= R_DATA;
            r_req_q <= ar_req;
            r_cnt_q <= '0;
            arready_q <= 1'h0;
            rvalid_q <= 1'h1;
            rlast_q <= (arlen == 8'h0);
            rdata_q <= mem[ar_word]; // RL18
          end
        R_DATA:
          if (r_fire && r_last_beat)
          begin
            r_state_q <= R_IDLE;
            arready_q <= 1'h1;
            rvalid_q <= 1'h0;
            rlast_q <= 1'h0;
          end
          else if (r_fire)
          begin
            // next beat placed as soon as the last one is taken
            r_req_q <= r_next; // RL2 RL4 RL23
            r_cnt_q <= r_cnt_q + 8'h1;
            rlast_q <= ((r_cnt_q + 8'h1) == r_req_q.len); // RL22
            rdata_q <= mem[rn_word];
          end
        default: r_state_q <= R_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rlast = rlast_q;
  assign rresp = rresp_q;
  assign rdata = rdata_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_bvalid_after_last: assert property ( // RL21
    w_fire && w_last_beat |=> bvalid_q && !wready_q)
    else $error("bvalid not raised after last beat");
  a_bvalid_cause: assert property ( // RL21
    $rose(bvalid_q) |-> $past(w_fire && w_last_beat))
    else $error("bvalid raised without last beat");
  a_beat_count: assert property ( // RL2
    w_fire && !w_last_beat |=> w_cnt_q == $past(w_cnt_q) + 8'h1)
    else $error("write beat not counted once");
  a_narrow_hold: assert property ( // RL4
    w_fire && !w_last_beat && w_req_q.burst == BURST_INCR &&
    w_req_q.size == SIZE_HALF && !w_req_q.addr[1]
    |=> w_word == $past(w_word))
    else $error("word advanced inside a word");
  a_narrow_step: assert property ( // RL4
    w_fire && !w_last_beat && w_req_q.burst == BURST_INCR &&
    w_req_q.size == SIZE_HALF && w_req_q.addr[1]
    |=> w_word == $past(w_word) + WORD_W'(1))
    else $error("word not advanced at boundary");
  a_strobe_write: assert property ( // RL3
    w_fire && wstrb[0] |=> mem[$past(w_word)][7:0] == $past(wdata[7:0]))
    else $error("strobed byte not written");
  a_offset_decode: assert property ( // RL9 RL10
    aw_fire |=> w_req_q.addr[1:0] ==
      (mem_slave_mode ? $past(awaddr[1:0]) : 2'h0))
    else $error("byte offset decoded wrongly");
  a_wrap_line: assert property ( // RL23
    r_fire && !r_last_beat && r_req_q.burst == BURST_WRAP
    |=> (r_req_q.addr & ~wrap_mask(r_req_q)) ==
        $past(r_req_q.addr & ~wrap_mask(r_req_q)))
    else $error("wrap left its line");
  a_rlast_end: assert property ( // RL22
    rvalid_q |-> rlast_q == r_last_beat)
    else $error("rlast off its beat");
  a_read_direct: assert property ( // RL18
    ar_fire |=> rvalid_q && rdata_q == $past(mem[ar_word]))
    else $error("read data not taken straight from ram");

  c_narrow_write: cover property (
    w_fire && w_last_beat && w_req_q.size == SIZE_HALF);
  c_wrap_read: cover property (
    r_fire && r_last_beat && r_req_q.burst == BURST_WRAP);
  c_unaligned: cover property (
    aw_fire && awsize == SIZE_WORD && awaddr[1:0] != 2'h0);

endmodule

// *** include/abrs_pkg.sv ***
// ----------------------------------------------------------------
// shared constants and carriers of the block ram slave
// ----------------------------------------------------------------
package abrs_pkg;

  // data path, one width on bus and memory side
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam int ADDR_W = 32;
  // byte address bits kept, a 4kB range
  localparam int MEM_AW = 12;
  localparam int DEPTH = 1024;
  // word index field of the byte address
  localparam int WORD_LSB = 2;
  localparam int WORD_W = 10;

  // burst type codes
  localparam logic [1:0] BURST_FIXED = 2'h0;
  localparam logic [1:0] BURST_INCR = 2'h1;
  localparam logic [1:0] BURST_WRAP = 2'h2;

  // beat size codes
  localparam logic [2:0] SIZE_HALF = 3'h1;
  localparam logic [2:0] SIZE_WORD = 3'h2;

  // response code
  localparam logic [1:0] RESP_OKAY = 2'h0;

  // reset values of handshake outputs
  localparam logic READY_RST = 1'h1;
  localparam logic VALID_RST = 1'h0;

  // captured burst request
  typedef struct packed {
    logic [MEM_AW-1:0] addr;
    logic [7:0] len;
    logic [2:0] size;
    logic [1:0] burst;
  } abrs_req_t;

endpackage

// *** verification/abrs_axi_master.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// bus master model facing the ram slave
// ----------------------------------------
module abrs_axi_master (
  // clock
  input wire logic aclk,
  // write side
  output logic [31:0] awaddr,
  output logic [7:0] awlen,
  output logic [2:0] awsize,
  output logic [1:0] awburst,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wlast,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  // read side
  output logic [31:0] araddr,
  output logic [7:0] arlen,
  output logic [2:0] arsize,
  output logic [1:0] arburst,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rlast,
  input wire logic rvalid,
  output logic rready
);
  // beat payloads and captured answers
  logic [31:0] wd [256];
  logic [3:0] ws [256];
  logic [31:0] rq [256];
  logic [255:0] rl;
  logic [1:0] bcode;
  logic [1:0] rcode;

  // idle levels at time zero
  initial
  begin
    {awaddr, awlen, awsize, awburst, awvalid, wdata, wstrb} = '0;
    {wlast, wvalid, bready, araddr, arlen, arsize} = '0;
    {arburst, arvalid, rready} = '0;
  end

  // one write burst, aw and first beat offered together
  task automatic wr(input logic [31:0] a, input logic [7:0] l,
    input logic [2:0] s, input logic [1:0] b, input int dly);
    int i;
    logic ad;
    i = 0;
    ad = 1'b0;
    awaddr <= a;
    awlen <= l;
    awsize <= s;
    awburst <= b;
    awvalid <= 1'b1;
    wdata <= wd[0];
    wstrb <= ws[0];
    wlast <= (l == 8'h0);
    wvalid <= 1'b1;
    while (!ad || i <= l)
    begin
      @(posedge aclk);
      // address taken: release, scramble the old value
      if (!ad && awready)
      begin
        ad = 1'b1;
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      // beat taken: next beat or release
      if (i <= l && wready)
      begin
        i++;
        wdata <= (i > l) ? ~wdata : wd[i[7:0]];
        wstrb <= ws[i[7:0]];
        wlast <= (i == l);
        wvalid <= (i <= l);
      end
    end
    // zero delay never stalls the response
    repeat (dly) @(posedge aclk);
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid);
    bcode = bresp;
    bready <= 1'b0;
  endtask

  // one read burst, rready raised dly cycles per beat
  task automatic rd(input logic [31:0] a, input logic [7:0] l,
    input logic [2:0] s, input logic [1:0] b, input int dly);
    araddr <= a;
    arlen <= l;
    arsize <= s;
    arburst <= b;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    araddr <= ~a;
    for (int i = 0; i <= l; i++)
    begin
      repeat (dly) @(posedge aclk);
      rready <= 1'b1;
      do @(posedge aclk); while (!rvalid);
      rq[i] = rdata;
      rl[i] = rlast;
      rcode = rresp;
      if (dly > 0 || i == l)
        rready <= 1'b0;
    end
  endtask
endmodule

// *** verification/axi_block_ram_slave_addressing_bench.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// self-checking bench of the ram slave
// ----------------------------------------
module axi_block_ram_slave_addressing_bench;
  import abrs_pkg::*;
  // clock, reset and bus wires
  logic aclk, aresetn;
  logic [31:0] awaddr, araddr, wdata, rdata;
  logic [7:0] awlen, arlen;
  logic [2:0] awsize, arsize;
  logic [1:0] awburst, arburst, bresp, rresp;
  logic [3:0] wstrb;
  logic awvalid, awready, wlast, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rlast, rvalid, rready;
  int fail_count, check_count;

  abrs_ram_slave uut (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awlen(awlen), .awsize(awsize), .awburst(awburst),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wlast(wlast), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arlen(arlen),
    .arsize(arsize), .arburst(arburst), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rlast(rlast),
    .rvalid(rvalid), .rready(rready));

  abrs_axi_master m (.aclk(aclk),
    .awaddr(awaddr), .awlen(awlen), .awsize(awsize), .awburst(awburst),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wlast(wlast), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arlen(arlen),
    .arsize(arsize), .arburst(arburst), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rlast(rlast),
    .rvalid(rvalid),
    .rready(rready));

  // compare of one data word
  task automatic chk_word(input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  // compare of a two-bit code or flag pair
  task automatic chk_resp(input logic [1:0] e, input logic [1:0] g);
    check_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  // verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // beat data k*01010101, strobes alternate s0/s1
  task automatic fill(input logic [3:0] s0, input logic [3:0] s1);
    for (int i = 0; i < 256; i++)
    begin
      m.wd[i] = 32'h01010101 * 32'(i + 1);
      m.ws[i] = i[0] ? s1 : s0;
    end
  endtask

  // half-word burst from an odd half, read back half by half
  task automatic t_narrow();
    fill(4'hc, 4'h3);
    m.wr(32'h1002, 8'h3, SIZE_HALF, BURST_INCR, 0);
    chk_resp(RESP_OKAY, m.bcode);
    m.rd(32'h1002, 8'h3, SIZE_HALF, BURST_INCR, 0);
    chk_word(32'h01010000, m.rq[0]);
    chk_word(32'h03030202, m.rq[1]);
    chk_word(32'h03030202, m.rq[2]);
    chk_word(32'h00000404, m.rq[3]);
  endtask

  // unaligned word burst, high address bits as aliases, then fixed burst
  task automatic t_unalign();
    fill(4'hc, 4'hf);
    m.wr(32'h3102, 8'h1, SIZE_WORD, BURST_INCR, 0);
    m.rd(32'ha000_0100, 8'h1, SIZE_WORD, BURST_INCR, 0);
    chk_word(32'h01010000, m.rq[0]);
    chk_word(32'h02020202, m.rq[1]);
    // fixed burst, both beats land on one word, last one wins
    m.wr(32'h300, 8'h1, SIZE_WORD, BURST_FIXED, 0);
    m.rd(32'h300, 8'h1, SIZE_WORD, BURST_FIXED, 0);
    chk_word(32'h02020202, m.rq[0]);
    chk_word(32'h02020202, m.rq[1]);
    chk_resp(RESP_OKAY, m.rcode);
  endtask

  // wrap read of a line with both response sides stalling
  task automatic t_wrap();
    fill(4'hf, 4'hf);
    m.wr(32'h200, 8'h3, SIZE_WORD, BURST_INCR, 3);
    chk_resp(RESP_OKAY, m.bcode);
    m.rd(32'h208, 8'h3, SIZE_WORD, BURST_WRAP, 2);
    for (int i = 0; i < 4; i++)
      chk_word(32'h01010101 * 32'((i + 2) % 4 + 1), m.rq[i]);
    chk_resp(2'h2, {m.rl[3], m.rl[2]});
  endtask

  // longest incrementing burst both ways
  task automatic t_long();
    fill(4'hf, 4'hf);
    m.wr(32'h800, 8'hff, SIZE_WORD, BURST_INCR, 0);
    m.rd(32'h800, 8'hff, SIZE_WORD, BURST_INCR, 0);
    for (int i = 0; i < 256; i++)
      chk_word(32'h01010101 * 32'(i + 1), m.rq[i]);
    chk_resp(2'h2, {m.rl[255], m.rl[254]});
  endtask

  // free-running clock
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // reset, then each scenario
  initial
  begin
    fail_count = 0;
    check_count = 0;
    aresetn = 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk_resp(2'h3, {awready, arready});
    chk_resp(2'h0, {bvalid, rvalid});
    t_narrow();
    t_unalign();
    t_wrap();
    t_long();
    results();
  end

  // watchdog far beyond the expected run
  initial
  begin
    repeat (5000) @(posedge aclk);
    fail_count++;
    results();
  end
endmodule
